// ---- rtl/storage_elements.v ----
// library of bistables, latches and flip-flops on one system clock
`timescale 1ns/1ns
`default_nettype none
`include "storage_regs.vh"

module storage_elements (
  input  wire                    ref_clk,
  input  wire                    reset,
  input  wire                    clk_en,
  // active-high set/clear bistable
  input  wire                    hi_set,
  input  wire                    hi_clear,
  output wire                    hi_out,
  output wire                    hi_inverted_out,
  // active-low set/clear bistable
  input  wire                    lo_set_n,
  input  wire                    lo_clear_n,
  output wire                    lo_out,
  output wire                    lo_inverted_out,
  // single-bit transparent latch
  input  wire                    lat_data,
  input  wire                    latch_open,
  output wire                    lat_out,
  output wire                    lat_inverted_out,
  // shared sampling strobe for the edge elements
  input  wire                    sample_clock,
  // edge d flip-flop
  input  wire                    dff_data,
  input  wire                    dff_preset_n,
  input  wire                    dff_clear_n,
  output wire                    dff_out,
  output wire                    dff_inverted_out,
  // jk flip-flop
  input  wire                    jk_j,
  input  wire                    jk_k,
  input  wire                    jk_k_low_mode,
  input  wire                    jk_set_n,
  input  wire                    jk_reset_n,
  output wire                    jk_out,
  output wire                    jk_inverted_out,
  // octal edge register
  input  wire [`OCTAL_WIDTH-1:0] reg_data,
  input  wire                    reg_out_en_n,
  output wire [`OCTAL_WIDTH-1:0] reg_out,
  output wire [`OCTAL_WIDTH-1:0] reg_oe,
  // octal transparent latch
  input  wire [`OCTAL_WIDTH-1:0] olat_data,
  input  wire                    olat_open,
  input  wire                    olat_out_en_n,
  output wire [`OCTAL_WIDTH-1:0] olat_out,
  output wire [`OCTAL_WIDTH-1:0] olat_oe
);

  //--------------------------------------------------------------------------
  // sample edge detection
  //--------------------------------------------------------------------------
  // sample_clock comes from logic on ref_clk, so it is read without a synchroniser
  // a strobe held high gives one event only; it must drop for an enabled cycle first
  reg  sample_prev_q;
  wire sample_rise;

  // strobe history, frozen with the rest of the state
  always @(posedge ref_clk)
  begin
    if (reset)
      sample_prev_q <= `BIT_RESET;
    else if (clk_en)
      sample_prev_q <= sample_clock;
  end

  // frozen clock enable masks the edge so no sample is taken while halted
  assign sample_rise = clk_en & sample_clock & ~sample_prev_q;

  //--------------------------------------------------------------------------
  // active-high bistable
  //--------------------------------------------------------------------------
  reg  hi_state_q;
  reg  hi_state_d;

  // the driver must not raise both controls; if it does, the old state is kept
  always @*
  begin
    hi_state_d = hi_state_q;
    if (hi_set && !hi_clear)
      hi_state_d = 1'b1;
    else if (hi_clear && !hi_set)
      hi_state_d = 1'b0;
  end

  // stored state of the high bistable
  always @(posedge ref_clk)
  begin
    if (reset)
      hi_state_q <= `BIT_RESET;
    else if (clk_en)
      hi_state_q <= hi_state_d;
  end

  reg  [1:0] hi_pins;

  // controls act on the outputs at once, storage catches up on the next clock
  always @*
  begin
    case ({hi_set, hi_clear})
      2'b10:   hi_pins = 2'b10;
      2'b01:   hi_pins = 2'b01;
      2'b11:   hi_pins = 2'b00;
      default: hi_pins = {hi_state_q, ~hi_state_q};
    endcase
  end

  // true output on the high bit, inverted output on the low bit
  assign hi_out          = hi_pins[1];
  assign hi_inverted_out = hi_pins[0];

  //--------------------------------------------------------------------------
  // active-low bistable
  //--------------------------------------------------------------------------
  reg  lo_state_q;
  reg  lo_state_d;

  // both low is the forbidden case, left to the driver; state is held then
  always @*
  begin
    lo_state_d = lo_state_q;
    if (!lo_set_n && lo_clear_n)
      lo_state_d = 1'b1;
    else if (!lo_clear_n && lo_set_n)
      lo_state_d = 1'b0;
  end

  // stored state of the low bistable
  always @(posedge ref_clk)
  begin
    if (reset)
      lo_state_q <= `BIT_RESET;
    else if (clk_en)
      lo_state_q <= lo_state_d;
  end

  reg  [1:0] lo_pins;

  // both controls low drive both outputs high, like cross-coupled nand gates
  always @*
  begin
    case ({lo_set_n, lo_clear_n})
      2'b01:   lo_pins = 2'b10;
      2'b10:   lo_pins = 2'b01;
      2'b00:   lo_pins = 2'b11;
      default: lo_pins = {lo_state_q, ~lo_state_q};
    endcase
  end

  // true output on the high bit, inverted output on the low bit
  assign lo_out          = lo_pins[1];
  assign lo_inverted_out = lo_pins[0];

  //--------------------------------------------------------------------------
  // single-bit transparent latch
  //--------------------------------------------------------------------------
  reg lat_state_q;

  // clock enable low freezes the stored bit but not the open path
  always @(posedge ref_clk)
  begin
    if (reset)
      lat_state_q <= `BIT_RESET;
    else if (clk_en && latch_open)
      lat_state_q <= lat_data;
  end

  // open latch is a wire from data to output; closed it shows the stored bit
  assign lat_out          = latch_open ? lat_data : lat_state_q;
  assign lat_inverted_out = ~lat_out;

  //--------------------------------------------------------------------------
  // edge d flip-flop with direct preset and clear
  //--------------------------------------------------------------------------
  reg  dff_state_q;
  reg  dff_state_d;

  // direct inputs beat the sample edge; preset wins when both are low
  always @*
  begin
    dff_state_d = dff_state_q;
    if (!dff_preset_n)
      dff_state_d = 1'b1;
    else if (!dff_clear_n)
      dff_state_d = 1'b0;
    else if (sample_rise)
      dff_state_d = dff_data;
  end

  // the flop itself; direct inputs reach it on the next enabled clock
  always @(posedge ref_clk)
  begin
    if (reset)
      dff_state_q <= `BIT_RESET;
    else if (clk_en)
      dff_state_q <= dff_state_d;
  end

  // direct inputs reach the outputs without waiting for any clock
  // both direct inputs low show high on both outputs, like the gate version
  assign dff_out          = !dff_preset_n ? 1'b1 : (!dff_clear_n ? 1'b0 : dff_state_q);
  assign dff_inverted_out = !dff_clear_n ? 1'b1 : (!dff_preset_n ? 1'b0 : ~dff_state_q);

  //--------------------------------------------------------------------------
  // jk flip-flop
  //--------------------------------------------------------------------------
  reg  jk_state_q;
  reg  jk_state_d;
  wire jk_k_eff;

  // the inverted-k variant is chosen by a static mode level
  assign jk_k_eff = jk_k_low_mode ? ~jk_k : jk_k;

  // direct inputs first, then the j/k action of a sample event
  always @*
  begin
    jk_state_d = jk_state_q;
    if (!jk_set_n)
      jk_state_d = 1'b1;
    else if (!jk_reset_n)
      jk_state_d = 1'b0;
    else if (sample_rise)
    begin
      case ({jk_j, jk_k_eff})
        2'b10:   jk_state_d = 1'b1;
        2'b01:   jk_state_d = 1'b0;
        2'b11:   jk_state_d = ~jk_state_q;
        default: jk_state_d = jk_state_q;
      endcase
    end
  end

  // stored state of the jk flop
  always @(posedge ref_clk)
  begin
    if (reset)
      jk_state_q <= `BIT_RESET;
    else if (clk_en)
      jk_state_q <= jk_state_d;
  end

  // direct set and reset override the outputs at once
  assign jk_out          = !jk_set_n ? 1'b1 : (!jk_reset_n ? 1'b0 : jk_state_q);
  assign jk_inverted_out = !jk_reset_n ? 1'b1 : (!jk_set_n ? 1'b0 : ~jk_state_q);

  //--------------------------------------------------------------------------
  // octal register and octal latch
  //--------------------------------------------------------------------------
  // enables go out as separate lines; the pad ring builds the floating pin
  // the latch copy ignores the sample strobe and the register copy the open level
  octal_store #(
    .KIND (`KIND_EDGE)
  ) u_octal_reg (
    .ref_clk     (ref_clk),
    .reset       (reset),
    .clk_en      (clk_en),
    .sample_rise (sample_rise),
    .latch_open  (1'b0),
    .data_in     (reg_data),
    .out_en_n    (reg_out_en_n),
    .data_out    (reg_out),
    .data_oe     (reg_oe)
  );

  octal_store #(
    .KIND (`KIND_LATCH)
  ) u_octal_latch (
    .ref_clk     (ref_clk),
    .reset       (reset),
    .clk_en      (clk_en),
    .sample_rise (1'b0),
    .latch_open  (olat_open),
    .data_in     (olat_data),
    .out_en_n    (olat_out_en_n),
    .data_out    (olat_out),
    .data_oe     (olat_oe)
  );

endmodule
`default_nettype wire

// ---- rtl/storage_regs.vh ----
// reset values and widths shared by the storage element library
`ifndef STORAGE_REGS_VH
`define STORAGE_REGS_VH

// width of the octal register and octal latch
`define OCTAL_WIDTH 8
// stored value of every single-bit element after reset
`define BIT_RESET 1'b0
// stored value of the octal elements after reset
`define OCTAL_RESET 8'h00
// octal element kinds
`define KIND_EDGE 1'b0
`define KIND_LATCH 1'b1

`endif

// ---- rtl/octal_store.v ----
// eight-bit storage word, edge sampled or level transparent, with output enable
`timescale 1ns/1ns
`default_nettype none
`include "storage_regs.vh"

module octal_store #(
  parameter [0:0] KIND = `KIND_EDGE
) (
  input  wire                    ref_clk,
  input  wire                    reset,
  input  wire                    clk_en,
  input  wire                    sample_rise,
  input  wire                    latch_open,
  input  wire [`OCTAL_WIDTH-1:0] data_in,
  input  wire                    out_en_n,
  output wire [`OCTAL_WIDTH-1:0] data_out,
  output wire [`OCTAL_WIDTH-1:0] data_oe
);

  //--------------------------------------------------------------------------
  // per-bit storage
  //--------------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < `OCTAL_WIDTH; i = i + 1)
    begin : g_bit
      reg  bit_q;
      wire bit_d;

      // edge kind loads on the sample edge, latch kind follows while open
      assign bit_d = (KIND == `KIND_EDGE) ? (sample_rise ? data_in[i] : bit_q)
                                          : (latch_open ? data_in[i] : bit_q);

      // contents are kept while outputs are disabled
      always @(posedge ref_clk)
      begin
        if (reset)
          bit_q <= `BIT_RESET;
        else if (clk_en)
          bit_q <= bit_d;
      end

      // an open latch passes data straight through, so it is not a flop output
      assign data_out[i] = (KIND == `KIND_LATCH && latch_open) ? data_in[i] : bit_q;
      // pin is driven only while the active-low enable is low
      assign data_oe[i]  = ~out_en_n;
    end
  endgenerate

endmodule
`default_nettype wire

// ---- bench/strobe_driver.sv ----
// surrounding logic that launches single sample strobes
`timescale 1ns/1ns
`default_nettype none

// -----------------------------------------------------------------
// strobe source
// -----------------------------------------------------------------
module strobe_driver (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic go,
  output var  logic sample_clock
);
  // registered so the strobe moves just after an edge, like any same-clock logic
  always @(posedge ref_clk)
    sample_clock <= reset ? 1'b0 : go;
endmodule
`default_nettype wire

// ---- bench/storage_elements_properties.sv ----
// port assertions for the storage element library
`timescale 1ns/1ns
`default_nettype none

// -----------------------------------------------------------------
// checker
// -----------------------------------------------------------------
module storage_elements_properties (
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       clk_en,
  input wire logic       hi_set,
  input wire logic       hi_clear,
  input wire logic       hi_out,
  input wire logic       hi_inverted_out,
  input wire logic       lo_set_n,
  input wire logic       lo_clear_n,
  input wire logic       lo_out,
  input wire logic       lo_inverted_out,
  input wire logic       jk_j,
  input wire logic       jk_k,
  input wire logic       jk_k_low_mode,
  input wire logic       jk_set_n,
  input wire logic       jk_reset_n,
  input wire logic       jk_out,
  input wire logic       latch_open,
  input wire logic       lat_data,
  input wire logic       lat_out,
  input wire logic       sample_clock,
  input wire logic       dff_data,
  input wire logic       dff_preset_n,
  input wire logic       dff_clear_n,
  input wire logic       dff_out,
  input wire logic       dff_inverted_out,
  input wire logic [7:0] reg_data,
  input wire logic       reg_out_en_n,
  input wire logic [7:0] reg_out,
  input wire logic [7:0] reg_oe,
  input wire logic       olat_open,
  input wire logic [7:0] olat_data,
  input wire logic [7:0] olat_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // sample event; the edge right after reset is skipped since history is cleared
  sequence s_rise;
    clk_en && $past(clk_en) && sample_clock && !$past(sample_clock) && !$past(reset);
  endsequence
  sequence s_direct_idle;
    dff_preset_n && dff_clear_n;
  endsequence
  // both j and the effective k high, direct inputs idle
  sequence s_jk_both;
    jk_j && (jk_k ^ jk_k_low_mode) && jk_set_n && jk_reset_n;
  endsequence
  a_lo_set_true: assert property (!lo_set_n && lo_clear_n |-> lo_out && !lo_inverted_out)
    else $error("low bistable set gives wrong outputs");
  a_jk_toggle: assert property (s_rise ##0 s_jk_both ##1 (jk_set_n && jk_reset_n) |-> jk_out == !$past(jk_out))
    else $error("jk flop did not toggle");
  a_hi_set_true: assert property (hi_set && !hi_clear |-> hi_out && !hi_inverted_out)
    else $error("high bistable set gives wrong outputs");
  a_hi_both_low: assert property (hi_set && hi_clear |-> !hi_out && !hi_inverted_out)
    else $error("high bistable both set outputs not low");
  a_lat_follows: assert property (latch_open |-> lat_out == lat_data)
    else $error("open latch not transparent");
  a_lat_holds: assert property (!latch_open && !$past(latch_open) && !$past(reset) |-> $stable(lat_out))
    else $error("closed latch output moved");
  a_dff_preset: assert property (!dff_preset_n && dff_clear_n |-> dff_out && !dff_inverted_out)
    else $error("direct preset not immediate");
  a_dff_capture: assert property (s_rise ##0 s_direct_idle ##1 s_direct_idle |-> dff_out == $past(dff_data))
    else $error("d flop sampled wrong value");
  a_reg_capture: assert property (s_rise |=> reg_out == $past(reg_data))
    else $error("octal register sampled wrong word");
  a_reg_enable: assert property (reg_oe == {8{!reg_out_en_n}})
    else $error("octal register enable wrong");
  a_olat_tracks: assert property (olat_open |-> olat_out == olat_data)
    else $error("open octal latch not tracking");
endmodule

bind storage_elements storage_elements_properties chk (.*);
`default_nettype wire

// ---- bench/storage_elements_test.sv ----
// self-checking bench for the storage element library
`timescale 1ns/1ns
`default_nettype none

module storage_elements_test;
  logic       ref_clk = 0, reset = 1, clk_en = 1, go = 0, sample_clock;
  logic       hi_set = 0, hi_clear = 0, lo_set_n = 1, lo_clear_n = 1, lat_data = 0, latch_open = 0;
  logic       dff_data = 0, dff_preset_n = 1, dff_clear_n = 1, jk_j = 0, jk_k = 0, jk_k_low_mode = 0;
  logic       jk_set_n = 1, jk_reset_n = 1, reg_out_en_n = 0, olat_open = 0, olat_out_en_n = 0;
  logic [7:0] reg_data = 8'h00, olat_data = 8'h00, reg_out, reg_oe, olat_out, olat_oe;
  logic       hi_out, hi_inverted_out, lo_out, lo_inverted_out, lat_out, lat_inverted_out;
  logic       dff_out, dff_inverted_out, jk_out, jk_inverted_out, q;
  logic [1:0] jk_seq [5] = '{2'h2, 2'h1, 2'h0, 2'h3, 2'h3};
  int         fails = 0, n_checks = 0;

  always #4 ref_clk = ~ref_clk;
  strobe_driver drv (.ref_clk(ref_clk), .reset(reset), .go(go), .sample_clock(sample_clock));
  storage_elements uut (.*);

  task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task tick;
    @(posedge ref_clk);
  endtask
  // one sample event; data must already be stable
  task fire;
    tick; go <= 1; tick; go <= 0; tick; #2;
  endtask
  task stop_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task t_bistables;
    tick; hi_set <= 1; lo_set_n <= 0; #2;
    chk("hi set", {hi_out, hi_inverted_out}, 2'h2);
    chk("lo set", {lo_out, lo_inverted_out}, 2'h2);
    tick; hi_set <= 0; lo_set_n <= 1; #2;
    chk("hi hold", {hi_out, hi_inverted_out}, 2'h2);
    chk("lo hold", {lo_out, lo_inverted_out}, 2'h2);
    tick; hi_clear <= 1; lo_clear_n <= 0; #2;
    chk("hi clear", {hi_out, hi_inverted_out}, 2'h1);
    chk("lo clear", {lo_out, lo_inverted_out}, 2'h1);
    tick; hi_set <= 1; lo_clear_n <= 1; #2;
    chk("hi both", {hi_out, hi_inverted_out}, 2'h0);
    // leave the both-high row through clear, never straight to hold
    tick; hi_set <= 0; #2;
    chk("hi leave", {hi_out, hi_inverted_out}, 2'h1);
    tick; hi_clear <= 0;
  endtask
  task t_latch;
    tick; latch_open <= 1; lat_data <= 1; #2;
    chk("lat open 1", lat_out, 1'b1);
    tick; lat_data <= 0; #2;
    chk("lat open 0", lat_out, 1'b0);
    tick; lat_data <= 1;
    tick; latch_open <= 0; lat_data <= 0;
    tick; tick; #2;
    chk("lat closed", {lat_out, lat_inverted_out}, 2'h2);
    tick; lat_data <= 1;
    tick; lat_data <= 0; #2;
    chk("lat still closed", lat_out, 1'b1);
  endtask
  task t_dff;
    tick; dff_data <= 1; fire;
    chk("dff cap 1", dff_out, 1'b1);
    tick; dff_data <= 0; #2;
    chk("dff between", dff_out, 1'b1);
    fire;
    chk("dff cap 0", dff_out, 1'b0);
    tick; dff_preset_n <= 0; #2;
    chk("dff preset", {dff_out, dff_inverted_out}, 2'h2);
    tick; dff_preset_n <= 1; dff_clear_n <= 0; #2;
    chk("dff clear", {dff_out, dff_inverted_out}, 2'h1);
    tick; dff_clear_n <= 1;
  endtask
  task t_jk;
    tick; jk_reset_n <= 0; #2;
    chk("jk reset", {jk_out, jk_inverted_out}, 2'h1);
    tick; jk_reset_n <= 1; jk_set_n <= 0; #2;
    chk("jk set", {jk_out, jk_inverted_out}, 2'h2);
    tick; jk_set_n <= 1; q = 1;
    // set, clear, hold, toggle twice
    for (int i = 0; i < 5; i++)
    begin
      tick; {jk_j, jk_k} <= jk_seq[i]; fire;
      q = (jk_seq[i] == 2'h2) ? 1'b1 : (jk_seq[i] == 2'h1) ? 1'b0 : (jk_seq[i] == 2'h3) ? ~q : q;
      chk("jk step", {jk_out, jk_inverted_out}, {q, ~q});
    end
    // low-active k: j high with k high means set
    tick; jk_k_low_mode <= 1; fire;
    chk("jk low k", {jk_out, jk_inverted_out}, 2'h2);
    tick; jk_k_low_mode <= 0; {jk_j, jk_k} <= 2'h0;
  endtask
  task t_octal;
    tick; reg_data <= 8'hA5; fire;
    chk("reg cap", reg_out, 8'hA5);
    chk("reg oe on", reg_oe, 8'hFF);
    tick; reg_out_en_n <= 1; reg_data <= 8'h3C; #2;
    chk("reg oe off", reg_oe, 8'h00);
    chk("reg kept", reg_out, 8'hA5);
    fire;
    chk("reg cap off", reg_out, 8'h3C);
    tick; reg_out_en_n <= 0; olat_open <= 1; olat_data <= 8'h5A; #2;
    chk("reg oe back", reg_oe, 8'hFF);
    chk("olat track", olat_out, 8'h5A);
    tick; olat_data <= 8'hC3;
    tick; olat_open <= 0; olat_data <= 8'h00;
    tick; olat_out_en_n <= 1; #2;
    chk("olat frozen", olat_out, 8'hC3);
    chk("olat oe off", olat_oe, 8'h00);
    tick; olat_out_en_n <= 0; #2;
    chk("olat oe on", olat_oe, 8'hFF);
    // a strobe while the clock enable is low must not sample
    tick; clk_en <= 0; reg_data <= 8'h81; fire;
    chk("reg frozen", reg_out, 8'h3C);
    tick; clk_en <= 1;
  endtask

  initial
  begin
    repeat (4) tick;
    reset <= 0;
    #2;
    chk("after reset", {hi_out, lat_out, dff_out, jk_out}, 4'h0);
    t_bistables;
    t_latch;
    t_dff;
    t_jk;
    t_octal;
    stop_test;
  end
  // whole run is about 75 cycles
  initial
  begin
    #20000;
    fails++;
    stop_test;
  end
endmodule
`default_nettype wire
